// ===== ihp_pin_logic.sv
// Host-side pin logic: reset filter, address latch, interrupt steering,
// 16-bit indications, strobe decode, serial configuration memory port.
// Assumes host strobes are asynchronous and the core supplies mode bits.
`timescale 1ns/1ps
module ihp_pin_logic
    import ihp_pkg::*;
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        powerdown,
    output logic                             core_reset,
    // Mode straps and configuration
    input  wire logic                        rom_select_or_card_mode,
    input  wire logic                        bus_16bit,
    input  wire logic [1:0]                  irq_line_select,
    input  wire logic [7:0]                  base_addr_high,
    input  wire logic [7:0]                  cor_value,
    input  wire logic                        encoder_decoder,
    output logic                             card_mode,
    // Host bus
    input  wire logic [ihp_pkg::ADDR_W-1:0]  host_addr,
    input  wire logic                        byte_high_n,
    input  wire logic                        bale_or_we,
    input  wire logic                        aen_or_reg,
    input  wire logic                        card_enable_n,
    input  wire logic                        io_read_strobe_n,
    input  wire logic                        io_write_strobe_n,
    input  wire logic                        rom_read_strobe_n,
    output logic [ihp_pkg::ADDR_W-1:0]       latched_addr,
    output logic                             latched_byte_high_n,
    output logic                             io_read,
    output logic                             io_write,
    output logic                             rom_read,
    output logic                             cfg_write,
    output logic                             cfg_read,
    // Interrupt pins
    input  wire logic                        core_irq,
    output logic [3:0]                       isa_irq_line,
    output logic [3:0]                       isa_irq_line_oe,
    output logic                             io16_n,
    output logic                             io16_n_oe,
    // Serial configuration memory
    input  wire logic                        ser_start,
    input  wire logic [ihp_pkg::SER_CMD_W-1:0] ser_cmd,
    input  wire logic [ihp_pkg::SER_CNT_W-1:0] ser_len,
    output logic                             ser_done,
    output logic [ihp_pkg::SER_CMD_W-1:0]    ser_rdata,
    output logic                             serial_cfg_clock,
    output logic                             serial_cfg_select,
    output logic                             serial_cfg_dout,
    input  wire logic                        serial_cfg_din,
    // Switches and transmit pin
    input  wire logic [2:0]                  base_select_switch,
    output logic [2:0]                       base_select_value,
    input  wire logic                        tx_active,
    output logic                             tx_activity_led_n,
    output logic                             tx_enable_n
);
    import ihp_pkg::*;

    // ****************************************************************
    // Reset filter and mode strap
    // ****************************************************************
    // The pin reset is treated as a level: a glitch must not clear the core unless powerdown is high.
    logic                    rst_sync;
    logic [RST_FILT_CYC-2:0] rhist_ff, nxt_rhist;
    logic                    nxt_core_reset, nxt_card_mode;

    ihp_sync2 u_rst_sync (.ref_clk(ref_clk), .rst(1'b0), .din(rst), .dout(rst_sync));

    // A history of pin samples, not a counter: an unknown power-up value
    // is shifted out while the pin is held, so it needs no reset of its own.
    always_comb begin
        nxt_rhist      = {rhist_ff[RST_FILT_CYC-3:0], rst_sync};
        nxt_core_reset = rst_sync && (powerdown || (&rhist_ff));
        nxt_card_mode  = card_mode;
        // Strap is captured while reset is held and frozen at release.
        if (core_reset) begin
            nxt_card_mode = ~rom_select_or_card_mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        rhist_ff   <= nxt_rhist;
        core_reset <= nxt_core_reset;
        card_mode  <= nxt_card_mode;
    end

    // ****************************************************************
    // Strobe synchronisers
    // ****************************************************************
    logic [3:0] strb_raw, strb_s;
    logic       bale_prev_ff;
    assign strb_raw = {bale_or_we, io_read_strobe_n, io_write_strobe_n, rom_read_strobe_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            ihp_sync2 u_s (.ref_clk(ref_clk), .rst(rst), .din(strb_raw[gi]),
                           .dout(strb_s[gi]));
        end
    endgenerate

    // ****************************************************************
    // Address latch, decode and strobes
    // ****************************************************************
    logic [ADDR_W-1:0] nxt_latched_addr;
    logic              nxt_latched_bhe, nxt_io_read, nxt_io_write, nxt_rom_read;
    logic              nxt_cfg_write, nxt_cfg_read, isa_hit, card_sel;

    assign isa_hit  = !aen_or_reg &&
                      (latched_addr[BASE_HI_BIT:BASE_LO_BIT] ==
                       {base_addr_high, 4'h0});
    assign card_sel = !card_enable_n;

    always_comb begin
        nxt_latched_addr = latched_addr;
        nxt_latched_bhe  = latched_byte_high_n;
        if (!card_mode && bale_prev_ff && !strb_s[3]) begin
            nxt_latched_addr = host_addr;
            nxt_latched_bhe  = byte_high_n;
        end
        nxt_io_read   = card_mode ? (!strb_s[2] && !aen_or_reg && cor_value[COR_FUNC_EN_BIT])
                                  : (!strb_s[2] && isa_hit);
        nxt_io_write  = card_mode ? (!strb_s[1] && !aen_or_reg && cor_value[COR_FUNC_EN_BIT])
                                  : (!strb_s[1] && isa_hit);
        nxt_rom_read  = !card_mode && !strb_s[0] && !aen_or_reg;
        nxt_cfg_read  = card_mode && !strb_s[0] && card_sel && aen_or_reg == 1'b0;
        nxt_cfg_write = card_mode && !strb_s[3] && card_sel && aen_or_reg == 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bale_prev_ff        <= 1'b1;
            latched_addr        <= ADDR_RST;
            latched_byte_high_n <= 1'b1;
            io_read             <= 1'b0;
            io_write            <= 1'b0;
            rom_read            <= 1'b0;
            cfg_read            <= 1'b0;
            cfg_write           <= 1'b0;
        end else begin
            bale_prev_ff        <= strb_s[3];
            latched_addr        <= nxt_latched_addr;
            latched_byte_high_n <= nxt_latched_bhe;
            io_read             <= nxt_io_read;
            io_write            <= nxt_io_write;
            rom_read            <= nxt_rom_read;
            cfg_read            <= nxt_cfg_read;
            cfg_write           <= nxt_cfg_write;
        end
    end

    // ****************************************************************
    // Interrupt pins and 16-bit indication
    // ****************************************************************
    logic [3:0] nxt_irq, nxt_irq_oe;
    logic       nxt_io16_n, nxt_io16_oe;

    always_comb begin
        nxt_irq    = 4'h0;
        nxt_irq_oe = 4'h0;
        if (card_mode) begin
            nxt_irq[0]    = ~core_irq;
            nxt_irq_oe[0] = 1'b1;
            nxt_irq[1]    = ~(card_sel && !strb_s[2]);
            nxt_irq_oe[1] = 1'b1;
        end else begin
            nxt_irq[irq_line_select]    = core_irq;
            nxt_irq_oe[irq_line_select] = 1'b1;
        end
        nxt_io16_n  = 1'b1;
        nxt_io16_oe = 1'b0;
        if (card_mode ? (bus_16bit && cor_value[COR_FUNC_EN_BIT] && !aen_or_reg)
                      : (bus_16bit && !aen_or_reg &&
                         host_addr[BASE_HI_BIT:BASE_LO_BIT] == {base_addr_high, 4'h0})) begin
            nxt_io16_n  = 1'b0;
            nxt_io16_oe = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            isa_irq_line    <= 4'h0;
            isa_irq_line_oe <= 4'h0;
            io16_n          <= 1'b1;
            io16_n_oe       <= 1'b0;
        end else begin
            isa_irq_line    <= nxt_irq;
            isa_irq_line_oe <= nxt_irq_oe;
            io16_n          <= nxt_io16_n;
            io16_n_oe       <= nxt_io16_oe;
        end
    end

    // ****************************************************************
    // Serial configuration memory
    // ****************************************************************
    ihp_ser_state_t          st_ff, nxt_st;
    logic [SK_CNT_W-1:0]     skc_ff, nxt_skc;
    logic [SER_CNT_W-1:0]    bits_ff, nxt_bits;
    logic [SER_CMD_W-1:0]    sh_ff, nxt_sh, nxt_rdata;
    logic                    nxt_sk, nxt_cs, nxt_do, nxt_done;
    logic                    half_tick;

    assign half_tick = (skc_ff == SK_CNT_W'(SK_HALF_CYC - 1));

    always_comb begin
        nxt_st    = st_ff;
        nxt_skc   = (st_ff == IHP_SER_SHIFT && !half_tick) ? skc_ff + 1'b1 : '0;
        nxt_bits  = bits_ff;
        nxt_sh    = sh_ff;
        nxt_rdata = ser_rdata;
        nxt_sk    = serial_cfg_clock;
        nxt_cs    = serial_cfg_select;
        nxt_do    = serial_cfg_dout;
        nxt_done  = 1'b0;
        unique case (st_ff)
            IHP_SER_IDLE: begin
                if (ser_start && ser_len != '0) begin
                    nxt_st   = IHP_SER_SHIFT;
                    nxt_cs   = 1'b1;
                    nxt_sh   = ser_cmd << (SER_CMD_W - ser_len);
                    nxt_bits = ser_len;
                    nxt_do   = nxt_sh[SER_CMD_W-1];
                end
            end
            IHP_SER_SHIFT: begin
                if (half_tick) begin
                    nxt_sk = ~serial_cfg_clock;
                    if (!serial_cfg_clock) begin
                        nxt_sh = {sh_ff[SER_CMD_W-2:0], serial_cfg_din};
                    end else begin
                        nxt_bits = bits_ff - 1'b1;
                        nxt_do   = sh_ff[SER_CMD_W-1];
                        if (bits_ff == SER_CNT_W'(1)) begin
                            nxt_st = IHP_SER_DONE;
                        end
                    end
                end
            end
            IHP_SER_DONE: begin
                nxt_cs    = 1'b0;
                nxt_do    = 1'b0;
                nxt_done  = 1'b1;
                nxt_rdata = sh_ff;
                nxt_st    = IHP_SER_IDLE;
            end
            default: nxt_st = IHP_SER_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff             <= IHP_SER_IDLE;
            skc_ff            <= '0;
            bits_ff           <= '0;
            sh_ff             <= SER_RST;
            ser_rdata         <= SER_RST;
            ser_done          <= 1'b0;
            serial_cfg_clock  <= 1'b0;
            serial_cfg_select <= 1'b0;
            serial_cfg_dout   <= 1'b0;
        end else begin
            st_ff             <= nxt_st;
            skc_ff            <= nxt_skc;
            bits_ff           <= nxt_bits;
            sh_ff             <= nxt_sh;
            ser_rdata         <= nxt_rdata;
            ser_done          <= nxt_done;
            serial_cfg_clock  <= nxt_sk;
            serial_cfg_select <= nxt_cs;
            serial_cfg_dout   <= nxt_do;
        end
    end

    // ****************************************************************
    // Switches and transmit pin
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            base_select_value <= 3'h7;
            tx_activity_led_n <= 1'b1;
            tx_enable_n       <= 1'b1;
        end else begin
            base_select_value <= base_select_switch;
            tx_activity_led_n <= !(tx_active && !encoder_decoder);
            tx_enable_n       <= !(tx_active && encoder_decoder);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence sk_rise_s;
        !serial_cfg_clock ##1 serial_cfg_clock;
    endsequence

    // 24 cycles of the 49-cycle high phase that follows the rising clock cycle.
    sequence sk_hold_s;
        serial_cfg_clock[*8] ##1 serial_cfg_clock[*8] ##1 serial_cfg_clock[*8];
    endsequence

    one_irq_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
        !card_mode |=> $onehot(isa_irq_line_oe)) else $error("irq enable not one-hot");
    card_irq_pol_a: assert property (@(posedge ref_clk) disable iff (rst)
        card_mode && $stable(card_mode) |=> isa_irq_line[0] == !$past(core_irq))
        else $error("card irq polarity wrong");
    sk_half_a: assert property (@(posedge ref_clk) disable iff (rst)
        sk_rise_s |=> sk_hold_s ##1 sk_hold_s ##1 serial_cfg_clock ##1 !serial_cfg_clock)
        else $error("serial clock high time wrong");
    cs_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
        serial_cfg_clock |-> serial_cfg_select) else $error("clock outside frame");
    done_cs_a: assert property (@(posedge ref_clk) disable iff (rst)
        ser_done |-> !serial_cfg_select) else $error("done while selected");
    io16_rel_a: assert property (@(posedge ref_clk) disable iff (rst)
        !io16_n |-> bus_16bit || $past(bus_16bit)) else $error("io16 without 16-bit");
    aen_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        !card_mode && $past(aen_or_reg) && $stable(card_mode) |-> !io_read && !io_write)
        else $error("decode while aen high");
    led_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(tx_activity_led_n == 1'b0 && tx_enable_n == 1'b0)) else $error("both tx pins low");
    rom_card_a: assert property (@(posedge ref_clk) disable iff (rst)
        card_mode && $stable(card_mode) |-> !rom_read) else $error("rom read in card mode");
endmodule // ihp_pin_logic

// ===== ihp_pkg.sv
// Package for the host-side pin logic of the network controller.
// Assumes a single 25 MHz reference clock and an active-high async reset.
package ihp_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_PERIOD_NS    = 40;
    localparam int          RST_MIN_NS       = 100;
    // Least time rounds up.
    localparam int          RST_FILT_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SK_PERIOD_NS     = 4000;
    localparam int          SK_HALF_CYC      = SK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ****************************************************************
    // Widths and field layout
    // ****************************************************************
    localparam int          SK_CNT_W         = 6;
    localparam int          RST_CNT_W        = 2;
    localparam int          ADDR_W           = 20;
    localparam int          BASE_LO_BIT      = 4;
    localparam int          BASE_HI_BIT      = 15;
    localparam int          BASE_W           = BASE_HI_BIT - BASE_LO_BIT + 1;
    localparam int          SER_CMD_W        = 16;
    localparam int          SER_CNT_W        = 5;
    localparam int          COR_FUNC_EN_BIT  = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_RST   = 20'h00000;
    localparam logic [SER_CMD_W-1:0] SER_RST = 16'h0000;

    typedef enum logic [1:0] {IHP_SER_IDLE, IHP_SER_SHIFT, IHP_SER_DONE} ihp_ser_state_t;

endpackage : ihp_pkg

// ===== ihp_sync2.sv
// Two-stage synchroniser for one host-side level.
// Assumes the input is asynchronous to ref_clk.
`timescale 1ns/1ps
module ihp_sync2 (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Level
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;

    // Only the second stage reads the first.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b1;
            dout    <= 1'b1;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule // ihp_sync2

// ===== ihp_ser_mem_model.sv
// Behavioural serial configuration memory for the host-side pin logic bench.
// Assumes the device frames each transfer with select and shifts on the serial clock.
`timescale 1ns/1ps
module ihp_ser_mem_model #(
    parameter logic [15:0] RDATA = 16'h3c96
) (
    // Serial pins
    input  wire logic        serial_cfg_clock,
    input  wire logic        serial_cfg_select,
    input  wire logic        serial_cfg_dout,
    output logic             serial_cfg_din,
    // Observation
    output logic [15:0]      rx_bits,
    output time              sk_period
);
    int  idx;
    time last_rise;

    initial begin
        serial_cfg_din = 1'b0;
        rx_bits        = 16'h0000;
        sk_period      = 0;
        last_rise      = 0;
        idx            = 0;
    end

    // Read data changes on the falling clock so the device samples a settled bit.
    // A released line falls to its pull-down level, not to the last bit sent.
    always @(posedge serial_cfg_select or negedge serial_cfg_select
             or negedge serial_cfg_clock) begin
        if (!serial_cfg_select) begin
            serial_cfg_din = 1'b0;
        end else if (idx == 0 || !serial_cfg_clock) begin
            serial_cfg_din = (idx < 16) ? RDATA[15 - idx] : 1'b0;
            idx = idx + 1;
        end
        if (!serial_cfg_select) begin
            idx = 0;
        end
    end

    always @(posedge serial_cfg_clock) begin
        if (serial_cfg_select) begin
            rx_bits = {rx_bits[14:0], serial_cfg_dout};
            if (last_rise != 0) begin
                sk_period = $time - last_rise;
            end
            last_rise = $time;
        end
    end
endmodule // ihp_ser_mem_model

// ===== isa_pcmcia_host_pin_logic_tb.sv
// Self-checking bench for the host-side pin logic.
// Assumes the design package and a 25 MHz reference clock.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module isa_pcmcia_host_pin_logic_tb;
    import ihp_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic ref_clk = 0, rst = 1, powerdown = 0, mode_pin = 1, bus_16bit = 0, enc = 0;
    logic [1:0] irq_sel = 0;
    logic [7:0] base_hi = 0, cor_value = 0;
    logic [ADDR_W-1:0] host_addr = 0, latched_addr;
    logic byte_high_n = 1, bale_or_we = 1, aen_or_reg = 1, card_enable_n = 1, core_irq = 0;
    logic [2:0] stb_n = 3'h7, sw = 3'h0, sw_value;
    logic ser_start = 0, tx_active = 0, core_reset, card_mode, latched_bhe_n, seen;
    logic [SER_CMD_W-1:0] ser_cmd = 0, ser_rdata, rx_bits;
    logic [SER_CNT_W-1:0] ser_len = 0;
    logic io_read, io_write, rom_read, cfg_write, cfg_read, io16_n, io16_n_oe, ser_done;
    logic [3:0] irq_line, irq_oe;
    logic sk, cs, sdo, sdi, led_n, txen_n;
    time sk_period;
    int failures = 0, checks_done = 0;
    wire [2:0] dec = {rom_read, io_write, io_read};

    always #20 ref_clk = ~ref_clk;

    ihp_pin_logic uut (.ref_clk(ref_clk), .rst(rst), .powerdown(powerdown),
        .core_reset(core_reset), .rom_select_or_card_mode(mode_pin), .bus_16bit(bus_16bit),
        .irq_line_select(irq_sel), .base_addr_high(base_hi), .cor_value(cor_value),
        .encoder_decoder(enc), .card_mode(card_mode), .host_addr(host_addr),
        .byte_high_n(byte_high_n), .bale_or_we(bale_or_we), .aen_or_reg(aen_or_reg),
        .card_enable_n(card_enable_n), .io_read_strobe_n(stb_n[0]),
        .io_write_strobe_n(stb_n[1]), .rom_read_strobe_n(stb_n[2]),
        .latched_addr(latched_addr), .latched_byte_high_n(latched_bhe_n), .io_read(io_read),
        .io_write(io_write), .rom_read(rom_read), .cfg_write(cfg_write), .cfg_read(cfg_read),
        .core_irq(core_irq), .isa_irq_line(irq_line), .isa_irq_line_oe(irq_oe),
        .io16_n(io16_n), .io16_n_oe(io16_n_oe), .ser_start(ser_start), .ser_cmd(ser_cmd),
        .ser_len(ser_len), .ser_done(ser_done), .ser_rdata(ser_rdata),
        .serial_cfg_clock(sk), .serial_cfg_select(cs), .serial_cfg_dout(sdo),
        .serial_cfg_din(sdi), .base_select_switch(sw), .base_select_value(sw_value),
        .tx_active(tx_active), .tx_activity_led_n(led_n), .tx_enable_n(txen_n));

    ihp_ser_mem_model mem (.serial_cfg_clock(sk), .serial_cfg_select(cs),
        .serial_cfg_dout(sdo), .serial_cfg_din(sdi), .rx_bits(rx_bits), .sk_period(sk_period));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Holds reset high for n cycles and reports whether the filtered reset appeared.
    task automatic pulse(input int n, output logic got);
        got = 1'b0;
        rst = 1'b1;
        for (int i = 0; i < n + 6; i++) begin
            step(1);
            if (i == n - 1) rst = 1'b0;
            if (core_reset === 1'b1) got = 1'b1;
        end
    endtask

    task automatic results();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        results();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        step(5);
        rst = 1'b0;
        step(3);
        `CHECK_EQ(card_mode, 1'b0)
        pulse(2, seen); `CHECK_EQ(seen, 1'b0)
        pulse(8, seen); `CHECK_EQ(seen, 1'b1)
        powerdown = 1'b1;
        pulse(2, seen); `CHECK_EQ(seen, 1'b1)
        powerdown = 1'b0;
        core_irq = 1'b1;
        for (int s = 0; s < 4; s++) begin
            irq_sel = s[1:0];
            step(4);
            `CHECK_EQ(irq_oe, 4'h1 << s)
            `CHECK_EQ(irq_line[s], 1'b1)
        end
        host_addr = 20'h5a5a5; byte_high_n = 1'b0; step(4);
        bale_or_we = 1'b0; step(4);
        host_addr = 20'h00000; byte_high_n = 1'b1; step(4);
        `CHECK_EQ(latched_addr, 20'h5a5a5)
        `CHECK_EQ(latched_bhe_n, 1'b0)
        bale_or_we = 1'b1;
        bus_16bit = 1'b1; base_hi = 8'h3a; host_addr = 20'h03a00; aen_or_reg = 1'b0; step(4);
        `CHECK_EQ({io16_n_oe, io16_n}, 2'b10)
        // The strobe decode compares against the latched address, so latch the base.
        bale_or_we = 1'b0;
        step(4);
        bale_or_we = 1'b1;
        step(4);
        `CHECK_EQ(latched_addr, 20'h03a00)
        for (int k = 0; k < 3; k++) begin
            aen_or_reg = 1'b0; stb_n = ~(3'h1 << k); step(4);
            `CHECK_EQ(dec, 3'h1 << k)
            aen_or_reg = 1'b1; step(4);
            `CHECK_EQ(dec[1:0], 2'b00)
            `CHECK_EQ(io16_n_oe, 1'b0)
            stb_n = 3'h7; step(4);
        end
        aen_or_reg = 1'b0; host_addr = 20'h03b00; step(4);
        `CHECK_EQ(io16_n_oe, 1'b0)
        ser_len = 5'h10; ser_cmd = 16'hc3a5; ser_start = 1'b1; step(1);
        ser_start = 1'b0; step(3);
        // A second start in mid-transfer must not disturb the frame on the wire.
        ser_cmd = 16'h0ff0; ser_start = 1'b1; step(1);
        ser_start = 1'b0;
        `CHECK_EQ(cs, 1'b1)
        for (int w = 0; w < 3000 && ser_done !== 1'b1; w++) step(1);
        `CHECK_EQ(ser_done, 1'b1)
        `CHECK_EQ(cs, 1'b0)
        `CHECK_EQ(rx_bits, 16'hc3a5)
        `CHECK_EQ(ser_rdata, 16'h3c96)
        `CHECK_EQ(sk_period, 64'd4000)
        mode_pin = 1'b0; rst = 1'b1; step(8);
        rst = 1'b0; step(3);
        mode_pin = 1'b1; step(4);
        `CHECK_EQ(card_mode, 1'b1)
        `CHECK_EQ({irq_oe[0], irq_line[0]}, 2'b10)
        card_enable_n = 1'b0; stb_n = 3'h6; step(4);
        `CHECK_EQ({irq_oe[1], irq_line[1]}, 2'b10)
        stb_n = 3'h7; cor_value = 8'h01; step(4);
        `CHECK_EQ({io16_n_oe, io16_n}, 2'b10)
        cor_value = 8'h00; step(4);
        `CHECK_EQ(io16_n_oe, 1'b0)
        bale_or_we = 1'b0; step(4);
        `CHECK_EQ(cfg_write, 1'b1)
        bale_or_we = 1'b1; stb_n = 3'h3; step(4);
        `CHECK_EQ(cfg_read, 1'b1)
        stb_n = 3'h7;
        sw = 3'h5; step(4);
        `CHECK_EQ(sw_value, 3'h5)
        sw = 3'h2; step(4);
        `CHECK_EQ(sw_value, 3'h2)
        tx_active = 1'b1; step(4);
        `CHECK_EQ(led_n, 1'b0)
        enc = 1'b1; step(4);
        `CHECK_EQ(txen_n, 1'b0)
        results();
    end
endmodule // isa_pcmcia_host_pin_logic_tb
